/* core/sib_core.sv */
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/100ps
module sib_core (
  input  wire logic        pclk,       // Module clock, 20 MHz
  input  wire logic        presetn,    // Async reset, active low
  input  wire logic [7:0]  paddr,      // APB byte address
  input  wire logic        psel,       // APB select
  input  wire logic        penable,    // APB access phase
  input  wire logic        pwrite,     // APB direction
  input  wire logic [31:0] pwdata,     // APB write data
  output logic      [31:0] prdata,     // APB read data
  output logic             pready,     // APB ready, always high
  output logic             pslverr,    // APB error on unmapped address
  input  wire logic        ser_in,     // Serial receive line
  output logic             ser_out,    // Serial transmit line
  output logic             ser_out_oe, // Transmit line driven
  output logic             irq         // Level interrupt
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sib_pkg::sib_ctrl_t     ctrl_reg, ctrl_next;
  logic [15:0]            baud_reg, baud_next, div_reg, div_next;
  logic [3:0]             status_reg, status_next, mask_reg, mask_next;
  sib_pkg::sib_evt_t      evt;
  sib_pkg::sib_tx_state_t tx_st_reg, tx_st_next;
  logic [10:0]            tx_sh_reg, tx_sh_next;
  logic [3:0]             tx_bits_reg, tx_bits_next, tx_rt_reg, tx_rt_next;
  logic                   tx_on_d_reg, idle_pend_reg, idle_pend_next;
  logic                   idle_frm_reg, idle_frm_next, buf_full_reg, buf_full_next;
  logic [8:0]             buf_reg, buf_next;
  logic                   tx_idle_evt;
  sib_pkg::sib_rx_state_t rx_st_reg, rx_st_next;
  logic [4:0]             rt_reg, rt_next;
  logic [1:0]             samp_reg, samp_next;
  logic [8:0]             rx_sh_reg, rx_sh_next, rx_data_reg, rx_data_next;
  logic [3:0]             rx_bits_reg, rx_bits_next;
  logic                   rx_act_reg, rx_act_next, rx_noise_evt, rx_frame_evt, rx_done_evt;
  logic [7:0]             idle_cnt_reg, idle_cnt_next;
  logic                   tick, wr, rd, v_maj, v_noise;
  logic [3:0]             char_len;

  // Idle character length in oversample ticks
  function automatic logic [7:0] idle_ticks(input logic long_char);
    idle_ticks = long_char ? 8'hB0 : 8'hA0;
  endfunction

  assign wr       = psel & penable & pwrite;
  assign rd       = psel & penable & ~pwrite;
  assign char_len = ctrl_reg.long_char ? sib_pkg::CHAR_LONG : sib_pkg::CHAR_SHORT;
  assign tick     = (div_reg == 16'h0000);
  assign evt      = '{idle_sent: tx_idle_evt, rx_done: rx_done_evt, framing: rx_frame_evt, noise: rx_noise_evt};

  // ----------------------------------------------------------------
  // APB slave and registers
  // ----------------------------------------------------------------
  // Zero wait states keep the slave trivial; reads are side-effect free
  always_comb begin
    ctrl_next   = ctrl_reg;
    baud_next   = baud_reg;
    mask_next   = mask_reg;
    status_next = status_reg;
    prdata      = 32'h0000_0000;
    pslverr     = 1'b0;
    if (wr && paddr == sib_pkg::OFF_CTRL) begin
      ctrl_next = sib_pkg::sib_ctrl_t'(pwdata[1:0]);
    end
    if (wr && paddr == sib_pkg::OFF_BAUD) begin
      baud_next = pwdata[15:0];
    end
    if (wr && paddr == sib_pkg::OFF_MASK) begin
      mask_next = pwdata[3:0];
    end
    if (wr && paddr == sib_pkg::OFF_STATUS) begin
      status_next = status_reg & ~pwdata[3:0];
    end
    status_next = status_next | evt; // Set wins over a same-cycle clear
    unique case (paddr)
      sib_pkg::OFF_CTRL:   prdata[1:0] = ctrl_reg;
      sib_pkg::OFF_BAUD:   prdata[15:0] = baud_reg;
      sib_pkg::OFF_STATUS: prdata[5:0] = {~buf_full_reg, rx_act_reg, status_reg};
      sib_pkg::OFF_MASK:   prdata[3:0] = mask_reg;
      sib_pkg::OFF_TXDATA: prdata = 32'h0000_0000;
      sib_pkg::OFF_RXDATA: prdata[8:0] = rx_data_reg;
      default:             pslverr = psel & penable;
    endcase
    if (!rd) begin
      prdata = 32'h0000_0000;
    end
    // Oversample divider: one tick every baud_reg+1 clocks
    div_next = tick ? baud_reg : div_reg - 16'h0001;
  end

  assign pready = 1'b1;
  assign irq    = |(status_reg & mask_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg   <= '0;
      baud_reg   <= sib_pkg::BAUD_RST;
      div_reg    <= sib_pkg::BAUD_RST;
      mask_reg   <= 4'h0;
      status_reg <= 4'h0;
    end else begin
      ctrl_reg   <= ctrl_next;
      baud_reg   <= baud_next;
      div_reg    <= div_next;
      mask_reg   <= mask_next;
      status_reg <= status_next;
    end
  end

  // ----------------------------------------------------------------
  // Transmitter: frames, preamble and queued idle characters
  // ----------------------------------------------------------------
  // Any rise of tx_on_bit arms one idle; a late rise after the stop bit
  // lets a waiting byte start first, and the armed idle is sent after that byte
  always_comb begin
    tx_st_next     = tx_st_reg;
    tx_sh_next     = tx_sh_reg;
    tx_bits_next   = tx_bits_reg;
    tx_rt_next     = tx_rt_reg;
    idle_pend_next = idle_pend_reg;
    idle_frm_next  = idle_frm_reg;
    buf_full_next  = buf_full_reg;
    buf_next       = buf_reg;
    tx_idle_evt    = 1'b0;
    if (ctrl_reg.tx_on && !tx_on_d_reg) begin
      idle_pend_next = 1'b1;
    end
    unique case (tx_st_reg)
      sib_pkg::TXS_WAIT: begin
        tx_rt_next = 4'h0;
        if (ctrl_reg.tx_on && idle_pend_reg) begin
          tx_sh_next     = 11'h7FF;
          tx_bits_next   = char_len;
          idle_frm_next  = 1'b1;
          idle_pend_next = 1'b0;
          tx_st_next     = sib_pkg::TXS_SHIFT;
        end else if (ctrl_reg.tx_on && buf_full_reg) begin
          tx_sh_next    = ctrl_reg.long_char ? {1'b1, buf_reg, 1'b0} : {2'b11, buf_reg[7:0], 1'b0};
          tx_bits_next  = char_len;
          idle_frm_next = 1'b0;
          buf_full_next = 1'b0;
          tx_st_next    = sib_pkg::TXS_SHIFT;
        end
      end
      sib_pkg::TXS_SHIFT: begin
        // The frame runs to its end whatever tx_on_bit does
        if (tick) begin
          tx_rt_next = tx_rt_reg + 4'h1;
          if (tx_rt_reg == 4'hF) begin
            tx_sh_next   = {1'b1, tx_sh_reg[10:1]};
            tx_bits_next = tx_bits_reg - 4'h1;
            if (tx_bits_reg == 4'h1) begin
              tx_st_next  = sib_pkg::TXS_WAIT;
              tx_idle_evt = idle_frm_reg;
            end
          end
        end
      end
    endcase
    if (wr && paddr == sib_pkg::OFF_TXDATA) begin
      buf_full_next = 1'b1;
      buf_next      = pwdata[8:0];
    end
  end

  assign ser_out    = tx_sh_reg[0];
  assign ser_out_oe = ctrl_reg.tx_on | (tx_st_reg == sib_pkg::TXS_SHIFT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_reg     <= sib_pkg::TXS_WAIT;
      tx_sh_reg     <= 11'h7FF;
      tx_bits_reg   <= 4'h0;
      tx_rt_reg     <= 4'h0;
      tx_on_d_reg   <= 1'b0;
      idle_pend_reg <= 1'b0;
      idle_frm_reg  <= 1'b0;
      buf_full_reg  <= 1'b0;
      buf_reg       <= 9'h000;
    end else begin
      tx_st_reg     <= tx_st_next;
      tx_sh_reg     <= tx_sh_next;
      tx_bits_reg   <= tx_bits_next;
      tx_rt_reg     <= tx_rt_next;
      tx_on_d_reg   <= ctrl_reg.tx_on;
      idle_pend_reg <= idle_pend_next;
      idle_frm_reg  <= idle_frm_next;
      buf_full_reg  <= buf_full_next;
      buf_reg       <= buf_next;
    end
  end

  // ----------------------------------------------------------------
  // Receiver: start search, verification and bit recovery
  // ----------------------------------------------------------------
  sib_vote u_vote (
    .samp  ({samp_reg, ser_in}),
    .maj   (v_maj),
    .noise (v_noise)
  );

  // Samples at 8 and 9 are held, the tick-10 sample is voted live
  always_comb begin
    rx_st_next    = rx_st_reg;
    rt_next       = rt_reg;
    samp_next     = samp_reg;
    rx_sh_next    = rx_sh_reg;
    rx_bits_next  = rx_bits_reg;
    rx_act_next   = rx_act_reg;
    idle_cnt_next = idle_cnt_reg;
    rx_data_next  = rx_data_reg;
    rx_noise_evt  = 1'b0;
    rx_frame_evt  = 1'b0;
    rx_done_evt   = 1'b0;
    if (tick) begin
      rt_next = (rt_reg == sib_pkg::RT16) ? sib_pkg::RT1 : rt_reg + 5'h01;
      if (rt_reg == sib_pkg::RT8 || rt_reg == sib_pkg::RT9) begin
        samp_next = {samp_reg[0], ser_in};
      end
      unique case (rx_st_reg)
        sib_pkg::RXS_SEARCH: begin
          rt_next = 5'h00;
          if (!ser_in) begin
            rx_act_next   = 1'b1;
            rt_next       = sib_pkg::RT1 + 5'h01;
            idle_cnt_next = 8'h00;
            rx_st_next    = sib_pkg::RXS_START;
          end else if (idle_cnt_reg == idle_ticks(ctrl_reg.long_char) - 8'h01) begin
            rx_act_next = 1'b0;
          end else begin
            idle_cnt_next = idle_cnt_reg + 8'h01;
          end
        end
        sib_pkg::RXS_START: begin
          if ((rt_reg == sib_pkg::RT3 || rt_reg == sib_pkg::RT5) && ser_in) begin
            rx_st_next = sib_pkg::RXS_SEARCH;
            rt_next    = 5'h00;
          end else if (rt_reg == sib_pkg::RT10) begin
            rx_noise_evt = v_noise | v_maj;
          end else if (rt_reg == sib_pkg::RT16) begin
            rx_bits_next = 4'h0;
            rx_st_next   = sib_pkg::RXS_DATA;
          end
        end
        sib_pkg::RXS_DATA: begin
          if (rt_reg == sib_pkg::RT10) begin
            rx_sh_next   = {v_maj, rx_sh_reg[8:1]};
            rx_noise_evt = v_noise;
          end else if (rt_reg == sib_pkg::RT16) begin
            rx_bits_next = rx_bits_reg + 4'h1;
            if (rx_bits_reg == char_len - 4'h3) begin
              rx_st_next = sib_pkg::RXS_STOP;
            end
          end
        end
        sib_pkg::RXS_STOP: begin
          if (rt_reg == sib_pkg::RT10) begin
            rx_frame_evt  = ~v_maj;
            rx_noise_evt  = v_noise;
            rx_done_evt   = 1'b1;
            rx_data_next  = ctrl_reg.long_char ? rx_sh_reg : {1'b0, rx_sh_reg[8:1]};
            idle_cnt_next = 8'h00;
            rt_next       = 5'h00;
            rx_st_next    = sib_pkg::RXS_SEARCH;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_reg    <= sib_pkg::RXS_SEARCH;
      rt_reg       <= 5'h00;
      samp_reg     <= 2'h3;
      rx_sh_reg    <= 9'h000;
      rx_bits_reg  <= 4'h0;
      rx_act_reg   <= 1'b0;
      idle_cnt_reg <= 8'h00;
      rx_data_reg  <= 9'h000;
    end else begin
      rx_st_reg    <= rx_st_next;
      rt_reg       <= rt_next;
      samp_reg     <= samp_next;
      rx_sh_reg    <= rx_sh_next;
      rx_bits_reg  <= rx_bits_next;
      rx_act_reg   <= rx_act_next;
      idle_cnt_reg <= idle_cnt_next;
      rx_data_reg  <= rx_data_next;
    end
  end

  // ----------------------------------------------------------------
  // Assertions and covers
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_IDLE_ONES: assert property (idle_frm_reg && tx_st_reg == sib_pkg::TXS_SHIFT |-> ser_out)
    else $error("idle character drove a zero");
  AST_PREAMBLE: assert property ($rose(ctrl_reg.tx_on) |=> ##1 (idle_pend_reg || idle_frm_reg))
    else $error("no idle armed after enable");
  AST_FINISH_FRAME: assert property ($fell(ctrl_reg.tx_on) && tx_bits_reg > 4'h1 |=> ser_out_oe)
    else $error("frame cut off when transmitter disabled");
  AST_QUEUE_IDLE: assert property (tx_st_reg == sib_pkg::TXS_SHIFT && ctrl_reg.tx_on && !tx_on_d_reg
    |=> idle_pend_reg until (tx_st_reg == sib_pkg::TXS_WAIT))
    else $error("toggle did not queue idle");
  AST_RELEASE: assert property (!ctrl_reg.tx_on && tx_st_reg == sib_pkg::TXS_WAIT
    |-> !ser_out_oe ##1 tx_st_reg == sib_pkg::TXS_WAIT)
    else $error("line held while disabled");
  AST_DATA_VOTE: assert property (tick && rx_st_reg == sib_pkg::RXS_DATA && rt_reg == sib_pkg::RT10
    |=> rx_sh_reg[8] == $past(v_maj))
    else $error("data bit not majority");
  AST_DATA_NOISE: assert property (tick && rx_st_reg == sib_pkg::RXS_DATA && rt_reg == sib_pkg::RT10
    && v_noise |=> status_reg[sib_pkg::ST_NOISE])
    else $error("noise not flagged on data bit");
  AST_START_NOISE: assert property (tick && rx_st_reg == sib_pkg::RXS_START && rt_reg == sib_pkg::RT10
    && v_maj |=> status_reg[sib_pkg::ST_NOISE] && rx_st_reg == sib_pkg::RXS_START)
    else $error("start bit sample handling wrong");
  AST_FRAMING: assert property (tick && rx_st_reg == sib_pkg::RXS_STOP && rt_reg == sib_pkg::RT10
    |=> status_reg[sib_pkg::ST_FRAME] == !$past(v_maj) || $past(status_reg[sib_pkg::ST_FRAME]))
    else $error("framing error mismatch");
  AST_STOP_NOISE: assert property (tick && rx_st_reg == sib_pkg::RXS_STOP && rt_reg == sib_pkg::RT10
    && v_noise |=> status_reg[sib_pkg::ST_NOISE])
    else $error("noise not flagged on stop bit");
  AST_FALSE_START: assert property (tick && rx_st_reg == sib_pkg::RXS_START && ser_in
    && (rt_reg == sib_pkg::RT3 || rt_reg == sib_pkg::RT5) |=> rx_st_reg == sib_pkg::RXS_SEARCH && rt_reg == 5'h00)
    else $error("false start not rejected");
  AST_RX_ACTIVE: assert property (tick && rx_st_reg == sib_pkg::RXS_SEARCH && !ser_in |=> rx_act_reg)
    else $error("receiver active not set");

  COV_IDLE_SENT: cover property (tx_idle_evt);
  COV_RX_DONE:   cover property (rx_done_evt && !rx_frame_evt);
  COV_FALSE:     cover property (rx_st_reg == sib_pkg::RXS_START ##1 rx_st_reg == sib_pkg::RXS_SEARCH);
  COV_FRAMING:   cover property (rx_frame_evt);
endmodule

/* core/sib_vote.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Three-sample majority voter with disagreement detect
// ----------------------------------------------------------------
module sib_vote (
  input  wire logic [2:0] samp,  // Samples at ticks 8, 9, 10
  output logic            maj,   // Majority value
  output logic            noise  // Samples not unanimous
);
  // Only 000 and 111 count as clean
  assign maj   = (samp[0] & samp[1]) | (samp[0] & samp[2]) | (samp[1] & samp[2]);
  assign noise = (samp != 3'h0) && (samp != 3'h7);
endmodule

/* shared/sib_pkg.sv */
package sib_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFF_CTRL   = 8'h00;
  localparam logic [7:0]  OFF_BAUD   = 8'h04;
  localparam logic [7:0]  OFF_STATUS = 8'h08;
  localparam logic [7:0]  OFF_MASK   = 8'h0C;
  localparam logic [7:0]  OFF_TXDATA = 8'h10;
  localparam logic [7:0]  OFF_RXDATA = 8'h14;
  localparam logic [15:0] BAUD_RST   = 16'h0082;
  // Status bit positions; 0..3 sticky, 4..5 live levels
  localparam int ST_NOISE = 0;
  localparam int ST_FRAME = 1;
  localparam int ST_RXDONE = 2;
  localparam int ST_IDLE  = 3;
  localparam int ST_RXACT = 4;
  localparam int ST_TXE   = 5;
  // ----------------------------------------------------------------
  // Oversample tick numbers and character lengths
  // ----------------------------------------------------------------
  localparam logic [4:0] RT1  = 5'h01;
  localparam logic [4:0] RT3  = 5'h03;
  localparam logic [4:0] RT5  = 5'h05;
  localparam logic [4:0] RT8  = 5'h08;
  localparam logic [4:0] RT9  = 5'h09;
  localparam logic [4:0] RT10 = 5'h0A;
  localparam logic [4:0] RT16 = 5'h10;
  localparam logic [3:0] CHAR_SHORT = 4'hA;
  localparam logic [3:0] CHAR_LONG  = 4'hB;

  typedef struct packed {
    logic long_char;
    logic tx_on;
  } sib_ctrl_t;

  typedef struct packed {
    logic idle_sent;
    logic rx_done;
    logic framing;
    logic noise;
  } sib_evt_t;

  typedef enum {TXS_WAIT, TXS_SHIFT} sib_tx_state_t;
  typedef enum {RXS_SEARCH, RXS_START, RXS_DATA, RXS_STOP} sib_rx_state_t;
endpackage

/* verification/sib_remote.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Remote transceiver; bench sets BAUD to zero, one tick per pclk
// ----------------------------------------------------------------
module sib_remote #(
  parameter int NB = 8  // Data bits per character
) (
  input  wire logic pclk,     // Bench clock
  input  wire logic line_in,  // Resolved transmit wire, pulled up
  output logic      line_out  // Drives the block's receive line
);
  logic [9:0] rx_q[$];  // Received {stop, data}
  int         st_q[$];  // Cycle stamp of each start edge
  int         cyc = 0;
  logic [9:0] sh;

  initial line_out = 1'b1;
  // Free cycle count for start stamps
  always @(posedge pclk) cyc <= cyc + 1;

  // One bit of 16 ticks; ticks 8..10 carry the pattern under test
  task automatic drive_bit(input logic [2:0] pat, input logic base);
    for (int t = 1; t <= 16; t++) begin
      line_out <= (t >= 8 && t <= 10) ? pat[10 - t] : base;
      @(posedge pclk);
    end
  endtask

  // Short low glitch, then the line returns high
  task automatic drive_low(input int n);
    line_out <= 1'b0;
    repeat (n) @(posedge pclk);
    line_out <= 1'b1;
    @(posedge pclk);
  endtask

  // Mid-bit sampler; an all-ones idle never starts it
  initial begin
    forever begin
      @(posedge pclk);
      if (line_in === 1'b0) begin
        st_q.push_back(cyc);
        sh = 10'h000;
        repeat (8) @(posedge pclk);
        for (int i = 0; i <= NB; i++) begin
          repeat (16) @(posedge pclk);
          sh[i] = line_in;
        end
        rx_q.push_back(sh);
      end
    end
  end
endmodule

/* verification/tb_sci_idle_and_bit_recovery.sv */
`timescale 1ns/100ps
module tb_sci_idle_and_bit_recovery;
  logic        pclk;
  logic        presetn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ser_in;
  logic        ser_out;
  logic        ser_out_oe;
  logic        irq;
  logic        tx_wire;
  logic [31:0] rd;
  logic        err;
  logic [31:0] seed;
  logic [9:0]  exp_tx[$];
  int          n_errors;
  int          num_checks;
  int          cyc;
  int          t_w;
  int          n0;

  // Pull-up holds the wire high whenever the block lets go
  assign tx_wire = ser_out_oe ? ser_out : 1'b1;

  sib_core dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ser_in(ser_in), .ser_out(ser_out), .ser_out_oe(ser_out_oe), .irq(irq));
  sib_remote u_rem (.pclk(pclk), .line_in(tx_wire), .line_out(ser_in));

  // ----------------------------------------------------------------
  // Clock, cycle count and helpers
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic maj3(input logic [2:0] p);
    return (p[0] & p[1]) | (p[1] & p[2]) | (p[0] & p[2]);
  endfunction

  task automatic chk_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_char(input string nm, input logic [9:0] exp, input logic [9:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task finish_test();
    if (n_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // APB transfer; entered right after a rising edge, leaves one idle cycle
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k == 50) n_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic clr();
    apb(sib_pkg::OFF_STATUS, 1'b1, 32'h0000000F);
  endtask

  // ----------------------------------------------------------------
  // Receive model: expected byte and flags from the drawn patterns
  // ----------------------------------------------------------------
  task automatic rx_char(input logic [8:0] d, input logic [2:0] spat, input logic [2:0] stp, input logic noisy,
                         input int nb = 8);
    logic [2:0] pat;
    logic [8:0] ed;
    logic       en;
    int         r;
    ed = 9'h000;
    en = (spat != 3'b000) | (stp != 3'b000 && stp != 3'b111);
    u_rem.drive_bit(spat, 1'b0);
    for (int i = 0; i < nb; i++) begin
      r = int'(rnd() % 4);
      pat = {3{d[i]}} ^ ((noisy && r != 0) ? (3'b001 << (r - 1)) : 3'b000);
      ed[i] = maj3(pat);
      en = en | (pat != 3'b000 && pat != 3'b111);
      u_rem.drive_bit(pat, ed[i]);
    end
    u_rem.drive_bit(stp, 1'b1);
    repeat (4) @(posedge pclk);
    apb(sib_pkg::OFF_RXDATA, 1'b0, 32'h0);
    chk_word("rx_data", {23'h0, ed}, rd);
    apb(sib_pkg::OFF_STATUS, 1'b0, 32'h0);
    chk_word("rx_flags", {29'h0, 1'b1, ~maj3(stp), en}, rd & 32'h7);
  endtask

  // ----------------------------------------------------------------
  // Transmit helpers
  // ----------------------------------------------------------------
  task automatic idle_time(input logic [31:0] ctrl, input int nbt);
    apb(sib_pkg::OFF_CTRL, 1'b1, ctrl);
    t_w = cyc;
    do apb(sib_pkg::OFF_STATUS, 1'b0, 32'h0); while (rd[3] !== 1'b1 && cyc - t_w < 400);
    chk_word("idle_len", 32'h1, {31'h0, (cyc - t_w >= 16 * nbt - 4 && cyc - t_w <= 16 * nbt + 12)});
    chk_word("idle_no_start", 32'h0, u_rem.rx_q.size());
    clr();
  endtask

  task automatic tx_send();
    void'(rnd());
    apb(sib_pkg::OFF_TXDATA, 1'b1, {24'h0, seed[7:0]});
    exp_tx.push_back({2'b01, seed[7:0]});
  endtask

  task automatic tx_wait();
    logic [9:0] got;
    int         k;
    got = 'x;
    k = 0;
    while (u_rem.rx_q.size() == 0 && k < 800) begin
      @(posedge pclk);
      k++;
    end
    if (u_rem.rx_q.size() != 0) got = u_rem.rx_q.pop_front();
    chk_char("tx_char", exp_tx.pop_front(), got);
  endtask

  // Hang guard, far beyond the few thousand cycles the run needs
  initial begin
    repeat (40000) @(posedge pclk);
    n_errors++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    seed = 32'h00000022;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(sib_pkg::OFF_BAUD, 1'b0, 32'h0);
    chk_word("baud_reset", {16'h0, sib_pkg::BAUD_RST}, rd);
    chk_word("pready_high", 32'h1, {31'h0, pready});
    apb(sib_pkg::OFF_MASK, 1'b0, 32'h0);
    chk_word("mask_reset", 32'h0, rd);
    apb(8'h20, 1'b0, 32'h0);
    chk_word("unmapped_err", 32'h1, {31'h0, err});
    chk_word("line_free", 32'h0, {31'h0, ser_out_oe});
    apb(sib_pkg::OFF_BAUD, 1'b1, 32'h0);
    // The divider only reloads once its reset count runs out; no ticks before that
    repeat (int'(sib_pkg::BAUD_RST) + 2) @(posedge pclk);
    // Interrupt raised, masked and cleared around one clean character
    apb(sib_pkg::OFF_MASK, 1'b1, 32'h00000004);
    rx_char(9'h0A5, 3'b000, 3'b111, 1'b0);
    chk_word("irq_on", 32'h1, {31'h0, irq});
    apb(sib_pkg::OFF_MASK, 1'b1, 32'h0);
    chk_word("irq_masked", 32'h0, {31'h0, irq});
    apb(sib_pkg::OFF_MASK, 1'b1, 32'h00000004);
    clr();
    chk_word("irq_cleared", 32'h0, {31'h0, irq});
    // Every stop-bit pattern, then noisy data and start bits
    for (int p = 0; p < 8; p++) begin
      void'(rnd());
      rx_char({1'b0, seed[7:0]}, 3'b000, p[2:0], 1'b0);
      clr();
    end
    for (int k = 0; k < 6; k++) begin
      void'(rnd());
      rx_char({1'b0, seed[7:0]}, seed[10:8], 3'b111, 1'b1);
      clr();
    end
    // Nine data bits in the long character mode
    apb(sib_pkg::OFF_CTRL, 1'b1, 32'h2);
    rx_char(9'h15A, 3'b000, 3'b111, 1'b0, 9);
    apb(sib_pkg::OFF_CTRL, 1'b1, 32'h0);
    clr();
    // False starts seen at tick 3 and at tick 5
    u_rem.drive_low(2);
    repeat (40) @(posedge pclk);
    apb(sib_pkg::OFF_STATUS, 1'b0, 32'h0);
    chk_word("false_start3", 32'h0, rd & 32'h7);
    u_rem.drive_low(4);
    repeat (40) @(posedge pclk);
    apb(sib_pkg::OFF_STATUS, 1'b0, 32'h0);
    chk_word("false_start5", 32'h0, rd & 32'h7);
    // Receiver active across a character and until an idle character
    fork
      rx_char(9'h03C, 3'b000, 3'b111, 1'b0);
      begin
        repeat (80) @(posedge pclk);
        apb(sib_pkg::OFF_STATUS, 1'b0, 32'h0);
        chk_word("rx_active_mid", 32'h1, {31'h0, rd[4]});
      end
    join
    apb(sib_pkg::OFF_STATUS, 1'b0, 32'h0);
    chk_word("rx_active_held", 32'h1, {31'h0, rd[4]});
    repeat (200) @(posedge pclk);
    apb(sib_pkg::OFF_STATUS, 1'b0, 32'h0);
    chk_word("rx_active_idle", 32'h0, {31'h0, rd[4]});
    clr();
    // Preamble, then a frame; then switch-off in mid-frame
    idle_time(32'h1, 10);
    tx_send();
    tx_wait();
    tx_send();
    repeat (40) @(posedge pclk);
    apb(sib_pkg::OFF_CTRL, 1'b1, 32'h0);
    chk_word("oe_in_frame", 32'h1, {31'h0, ser_out_oe});
    tx_wait();
    repeat (20) @(posedge pclk);
    chk_word("oe_released", 32'h0, {31'h0, ser_out_oe});
    idle_time(32'h3, 11);
    apb(sib_pkg::OFF_CTRL, 1'b1, 32'h0);
    // Toggle in mid-frame queues one idle before the next byte
    idle_time(32'h1, 10);
    n0 = u_rem.st_q.size();
    tx_send();
    repeat (40) @(posedge pclk);
    apb(sib_pkg::OFF_CTRL, 1'b1, 32'h0);
    apb(sib_pkg::OFF_CTRL, 1'b1, 32'h1);
    tx_send();
    tx_wait();
    tx_wait();
    t_w = (u_rem.st_q.size() > n0 + 1) ? u_rem.st_q[n0 + 1] - u_rem.st_q[n0] : 0;
    chk_word("queued_idle_gap", 32'h1, {31'h0, (t_w >= 318 && t_w <= 334)});
    apb(sib_pkg::OFF_STATUS, 1'b0, 32'h0);
    chk_word("queued_idle_flag", 32'h1, {31'h0, rd[3]});
    finish_test();
  end
endmodule
